// [wwd_core.sv]
`timescale 1ns/1ps
// Contract
// - reset output low at power-up, low supply
// - hold reset 10 ticks after supply good
// - valid trigger: low 10us to 5ms
// - sync trigger within 450 ticks: windowed
// - no sync trigger in 450: pulse, resync
// - short mode: closed 15, open 10
// - long mode: closed 1500, open 1000
// - trigger in closed window: pulse, resync
// - trigger in open window: new closed
// - no trigger whole window: pulse, resync
// - select high long, low short
// - select rising in short: long timing
// - select falling in long: short timing
// - reset pulse lasts 4 ticks
// - trigger during reset restarts pulse count
// - disable input low stops supervision
// - overlong trigger low holds reset low
module wwd_core #(
    parameter int unsigned POR_T   = wwd_pkg::POR_TICKS,
    parameter int unsigned SYNC_T  = wwd_pkg::SYNC_TICKS,
    parameter int unsigned SCLOSE  = wwd_pkg::SHORT_CLOSE,
    parameter int unsigned SOPEN   = wwd_pkg::SHORT_OPEN,
    parameter int unsigned LCLOSE  = wwd_pkg::LONG_CLOSE,
    parameter int unsigned LOPEN   = wwd_pkg::LONG_OPEN,
    parameter int unsigned PULSE_T = wwd_pkg::PULSE_TICKS,
    parameter int unsigned TRIG_MIN = wwd_pkg::TRIG_MIN_CYC,
    parameter int unsigned TRIG_MAX = wwd_pkg::TRIG_MAX_CYC
) (
    input  wire logic clk_i,             // 100 MHz system clock
    input  wire logic reset_i,           // sync reset, active high
    input  wire logic supply_ok_i,       // supply above threshold, async
    input  wire logic tick_i,            // one-cycle timer period pulse
    input  wire logic trigger_in_i,      // trigger pin, async
    input  wire logic long_mode_i,       // window select pin, async
    input  wire logic supervise_off_n_i, // disable pin, async, low off
    output logic      reset_out_n_o,     // reset to controller, low active
    output logic      synced_o,          // in windowed operation
    output logic      window_open_o      // open window active
);
    localparam int W = wwd_pkg::TICK_W;

    wwd_pkg::wwd_pins_s  pins;
    wwd_pkg::wwd_state_e state_q;
    logic [W-1:0]        cnt_q;
    logic                supply_ok;

    // closed window length for current select level
    function automatic logic [W-1:0] close_len(input logic lng);
        return lng ? W'(LCLOSE) : W'(SCLOSE);
    endfunction

    // open window length for current select level
    function automatic logic [W-1:0] open_len(input logic lng);
        return lng ? W'(LOPEN) : W'(SOPEN);
    endfunction

    // pins come from outside the clock domain
    wwd_pin_sync #(.RST_VAL(1'b1)) u_sync_trig (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (trigger_in_i),
        .level_o (pins.trigger_in)
    );

    wwd_pin_sync #(.RST_VAL(1'b1)) u_sync_mode (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (long_mode_i),
        .level_o (pins.long_mode)
    );

    wwd_pin_sync #(.RST_VAL(1'b1)) u_sync_dis (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (supervise_off_n_i),
        .level_o (pins.supervise_on)
    );

    // supply comparator starts low so reset is held from the start
    wwd_pin_sync #(.RST_VAL(1'b0)) u_sync_sup (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (supply_ok_i),
        .level_o (supply_ok)
    );

    wwd_trigger_check #(
        .MIN_CYC (TRIG_MIN),
        .MAX_CYC (TRIG_MAX)
    ) u_trig (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .trig_i  (pins.trigger_in),
        .valid_o (pins.valid_trigger_pulse),
        .error_o (pins.trigger_error)
    );

    // supervision state machine; every count advances only on a tick
    always_ff @(posedge clk_i) begin
        if (reset_i || !supply_ok) begin
            state_q <= wwd_pkg::WWD_POR;
            cnt_q   <= '0;
        end else if (!pins.supervise_on && state_q != wwd_pkg::WWD_POR) begin
            // disabled: park in sync monitoring, no reset issued
            state_q <= wwd_pkg::WWD_SYNC;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                wwd_pkg::WWD_POR: begin
                    if (tick_i) begin
                        if (cnt_q >= W'(POR_T - 1)) begin
                            state_q <= wwd_pkg::WWD_SYNC;
                            cnt_q   <= '0;
                        end else begin
                            cnt_q <= cnt_q + W'(1);
                        end
                    end
                end
                wwd_pkg::WWD_SYNC: begin
                    if (pins.valid_trigger_pulse) begin
                        state_q <= wwd_pkg::WWD_CLOSED;
                        cnt_q   <= '0;
                    end else if (tick_i) begin
                        if (cnt_q >= W'(SYNC_T - 1)) begin
                            state_q <= wwd_pkg::WWD_PULSE;
                            cnt_q   <= '0;
                        end else begin
                            cnt_q <= cnt_q + W'(1);
                        end
                    end
                end
                wwd_pkg::WWD_CLOSED: begin
                    // select level read live, so a change retimes at once
                    if (pins.valid_trigger_pulse) begin
                        state_q <= wwd_pkg::WWD_PULSE;
                        cnt_q   <= '0;
                    end else if (tick_i) begin
                        if (cnt_q >= close_len(pins.long_mode) - W'(1)) begin
                            state_q <= wwd_pkg::WWD_OPEN;
                            cnt_q   <= '0;
                        end else begin
                            cnt_q <= cnt_q + W'(1);
                        end
                    end
                end
                wwd_pkg::WWD_OPEN: begin
                    if (pins.valid_trigger_pulse) begin
                        state_q <= wwd_pkg::WWD_CLOSED;
                        cnt_q   <= '0;
                    end else if (tick_i) begin
                        if (cnt_q >= open_len(pins.long_mode) - W'(1)) begin
                            state_q <= wwd_pkg::WWD_PULSE;
                            cnt_q   <= '0;
                        end else begin
                            cnt_q <= cnt_q + W'(1);
                        end
                    end
                end
                wwd_pkg::WWD_PULSE: begin
                    if (pins.valid_trigger_pulse) begin
                        cnt_q <= '0;
                    end else if (tick_i) begin
                        if (cnt_q >= W'(PULSE_T - 1)) begin
                            state_q <= wwd_pkg::WWD_SYNC;
                            cnt_q   <= '0;
                        end else begin
                            cnt_q <= cnt_q + W'(1);
                        end
                    end
                end
                default: begin
                    state_q <= wwd_pkg::WWD_POR;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // output low in power-on, pulse, and while trigger is stuck low with supervision on
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_out_n_o <= 1'b0;
        end else begin
            reset_out_n_o <= supply_ok
                && state_q != wwd_pkg::WWD_POR
                && state_q != wwd_pkg::WWD_PULSE
                && !(pins.trigger_error && pins.supervise_on);
        end
    end

    // status flags for observation
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            synced_o      <= 1'b0;
            window_open_o <= 1'b0;
        end else begin
            synced_o      <= state_q == wwd_pkg::WWD_CLOSED
                          || state_q == wwd_pkg::WWD_OPEN;
            window_open_o <= state_q == wwd_pkg::WWD_OPEN;
        end
    end
endmodule // wwd_core

// [wwd_core_bench.sv]
`timescale 1ns/1ps
// scaled tick of 20 cycles keeps long windows short in simulation
module wwd_core_bench;
    localparam int TP = 20;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        supply_ok_i = 1'b1;
    logic        tick_i = 1'b0;
    logic        long_mode_i = 1'b0;
    logic        supervise_off_n_i = 1'b1;
    logic        go = 1'b0;
    logic [19:0] len = 20'h00000;
    logic        trigger;
    logic        reset_out_n_o;
    logic        synced_o;
    logic        window_open_o;
    int          tc = 0;
    int          n_fail = 0;
    int          samples_checked = 0;
    wwd_core #(.LCLOSE(30), .LOPEN(20), .TRIG_MIN(10), .TRIG_MAX(200))
    dut_u (.clk_i(clk_i), .reset_i(reset_i), .supply_ok_i(supply_ok_i),
        .tick_i(tick_i), .trigger_in_i(trigger), .long_mode_i(long_mode_i),
        .supervise_off_n_i(supervise_off_n_i), .synced_o(synced_o),
        .reset_out_n_o(reset_out_n_o), .window_open_o(window_open_o));
    wwd_mcu_model mcu_u (.clk_i(clk_i), .go_i(go), .len_i(len),
        .trigger_o(trigger));
    initial forever #5 clk_i = ~clk_i;
    // timer period pulse
    always @(posedge clk_i) begin
        tc     <= (tc == TP - 1) ? 0 : tc + 1;
        tick_i <= (tc == TP - 1);
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic close_out();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: output level", $time);
        end
    endtask
    function automatic logic pin(input int w);
        return (w == 0) ? reset_out_n_o : (w == 1) ? synced_o : window_open_o;
    endfunction
    // look just after the edge so its updates have landed
    task automatic look(input int w, input logic v);
        #1;
        chk(pin(w), v);
    endtask
    task automatic wait_for(input int w, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            #1;
            if (pin(w) === v) break;
            @(posedge clk_i);
        end
        chk(pin(w), v);
        if (i == lim) close_out();
    endtask
    task automatic trig(input int n, input int tail);
        @(posedge clk_i);
        go  <= 1'b1;
        len <= n[19:0];
        @(posedge clk_i);
        go  <= 1'b0;
        step(n + tail);
    endtask
    task automatic sync_up();
        trig(50, 8);
        wait_for(1, 1'b1, 40);
    endtask
    // cycles spent with reset low, looked at once the edge has settled
    task automatic low_time(output int n);
        for (n = 0; n < 800; n++) begin
            #1;
            if (reset_out_n_o === 1'b1) break;
            @(posedge clk_i);
        end
        // a reset that never ends is a hang, not a long pulse
        if (n == 800) begin
            chk(1'b0, 1'b1);
            close_out();
        end
    endtask
    task automatic t_power();
        step(8 * TP);
        look(0, 1'b0);
        wait_for(0, 1'b1, 5 * TP);
        look(1, 1'b0);
    endtask
    task automatic t_open_closed();
        int n;
        sync_up();
        wait_for(2, 1'b1, 16 * TP);
        trig(50, 8);
        look(2, 1'b0);
        look(0, 1'b1);
        step(2 * TP);
        trig(50, 0);
        wait_for(0, 1'b0, 20);
        trig(50, 0);
        low_time(n);
        chk(n > 2 * TP, 1'b1);
    endtask
    task automatic t_short_and_timeout();
        int n;
        sync_up();
        wait_for(2, 1'b1, 16 * TP);
        trig(5, 8);
        look(2, 1'b1);
        wait_for(0, 1'b0, 12 * TP);
        low_time(n);
        chk(n > 3 * TP && n <= 4 * TP + 8, 1'b1);
        step(440 * TP);
        look(0, 1'b1);
        wait_for(0, 1'b0, 15 * TP);
        wait_for(0, 1'b1, 6 * TP);
    endtask
    task automatic t_modes_error();
        long_mode_i <= 1'b1;
        sync_up();
        step(18 * TP);
        look(2, 1'b0);
        wait_for(2, 1'b1, 14 * TP);
        trig(50, 8);
        step(2 * TP);
        long_mode_i <= 1'b0;
        wait_for(2, 1'b1, 15 * TP);
        trig(50, 8);
        step(TP);
        long_mode_i <= 1'b1;
        step(22 * TP);
        look(2, 1'b0);
        trig(300, -50);
        look(0, 1'b0);
        step(60);
        look(0, 1'b1);
        wait_for(0, 1'b0, 40 * TP);
        wait_for(0, 1'b1, 6 * TP);
    endtask
    task automatic t_off_supply();
        supervise_off_n_i <= 1'b0;
        step(460 * TP);
        look(0, 1'b1);
        look(1, 1'b0);
        supervise_off_n_i <= 1'b1;
        supply_ok_i <= 1'b0;
        step(10);
        look(0, 1'b0);
        supply_ok_i <= 1'b1;
        step(5 * TP);
        look(0, 1'b0);
        wait_for(0, 1'b1, 8 * TP);
        // a stale power-on count would cut the sync wait short
        step(445 * TP);
        look(0, 1'b1);
        wait_for(0, 1'b0, 10 * TP);
    endtask
    initial begin
        step(5);
        reset_i <= 1'b0;
        t_power();
        t_open_closed();
        t_short_and_timeout();
        t_modes_error();
        t_off_supply();
        close_out();
    end
endmodule // wwd_core_bench

// [wwd_core_properties.sv]
`timescale 1ns/1ps
// pin-level checks; ticks counted per visible output phase
module wwd_core_properties #(
    parameter int unsigned SYNC_T   = wwd_pkg::SYNC_TICKS,
    parameter int unsigned SCLOSE   = wwd_pkg::SHORT_CLOSE,
    parameter int unsigned SOPEN    = wwd_pkg::SHORT_OPEN,
    parameter int unsigned LCLOSE   = wwd_pkg::LONG_CLOSE,
    parameter int unsigned LOPEN    = wwd_pkg::LONG_OPEN,
    parameter int unsigned PULSE_T  = wwd_pkg::PULSE_TICKS,
    parameter int unsigned TRIG_MAX = wwd_pkg::TRIG_MAX_CYC
) (
    input wire logic clk_i,             // system clock
    input wire logic reset_i,           // sync reset
    input wire logic supply_ok_i,       // supply good
    input wire logic tick_i,            // timer period
    input wire logic trigger_in_i,      // trigger pin
    input wire logic long_mode_i,       // window select
    input wire logic supervise_off_n_i, // low stops supervision
    input wire logic reset_out_n_o,     // reset output
    input wire logic synced_o,          // windowed operation
    input wire logic window_open_o      // open window
);
    logic [wwd_pkg::TICK_W-1:0] ph_q;
    logic [wwd_pkg::LOW_W-1:0]  low_q;
    logic [2:0]                 ph_sig;
    int unsigned                cl_len;
    int unsigned                op_len;
    assign ph_sig = {reset_out_n_o, synced_o, window_open_o};
    assign cl_len = long_mode_i ? LCLOSE : SCLOSE;
    assign op_len = long_mode_i ? LOPEN : SOPEN;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // output lags state by a cycle, so one tick may fall either side
    always_ff @(posedge clk_i) begin
        if (reset_i || !supervise_off_n_i || $changed(ph_sig)) begin
            ph_q <= '0;
        end else if (tick_i) begin
            ph_q <= ph_q + 1'b1;
        end
    end
    // saturating low-time counter for the trigger pin
    always_ff @(posedge clk_i) begin
        if (reset_i || trigger_in_i) begin
            low_q <= '0;
        end else if (low_q != '1) begin
            low_q <= low_q + 1'b1;
        end
    end
    sequence supply_low_s;
        !supply_ok_i [*8];
    endsequence
    sequence closed_end_s;
        synced_o && !window_open_o ##1 window_open_o;
    endsequence
    por_hold_a: assert property ($fell(reset_i) |-> !reset_out_n_o)
        else $error("reset output high after reset");
    supply_low_a: assert property (supply_low_s |-> !reset_out_n_o)
        else $error("reset output high with supply low");
    sync_wait_a: assert property (reset_out_n_o && !synced_o
        |-> ph_q <= SYNC_T + 1) else $error("sync wait too long");
    close_len_a: assert property (closed_end_s
        |-> ph_q == cl_len || ph_q + 1 == cl_len)
        else $error("closed window length off");
    open_len_a: assert property ($fell(window_open_o)
        |-> ph_q <= op_len) else $error("open window too long");
    pulse_len_a: assert property ($rose(reset_out_n_o) && !synced_o
        && $past(trigger_in_i, 8) |-> ph_q >= PULSE_T - 1)
        else $error("reset pulse too short");
    synced_rise_a: assert property ($rose(synced_o) |-> reset_out_n_o)
        else $error("windowed while reset low");
    open_retrig_a: assert property ($fell(window_open_o) && synced_o
        |-> reset_out_n_o) else $error("reset on open window trigger");
    off_park_a: assert property (!supervise_off_n_i [*8] |-> !synced_o)
        else $error("windowed while disabled");
    trig_error_a: assert property (low_q > TRIG_MAX + 8
        && supervise_off_n_i |-> !reset_out_n_o)
        else $error("reset high with trigger stuck low");
endmodule // wwd_core_properties
bind wwd_core wwd_core_properties #(
    .SYNC_T(SYNC_T), .SCLOSE(SCLOSE), .SOPEN(SOPEN), .LCLOSE(LCLOSE),
    .LOPEN(LOPEN), .PULSE_T(PULSE_T), .TRIG_MAX(TRIG_MAX)
) chk_u (
    .clk_i(clk_i), .reset_i(reset_i), .supply_ok_i(supply_ok_i),
    .tick_i(tick_i), .trigger_in_i(trigger_in_i),
    .long_mode_i(long_mode_i), .supervise_off_n_i(supervise_off_n_i),
    .reset_out_n_o(reset_out_n_o), .synced_o(synced_o),
    .window_open_o(window_open_o)
);

// [wwd_mcu_model.sv]
`timescale 1ns/1ps
// controller side: one low trigger pulse of len_i cycles per request
module wwd_mcu_model (
    input  wire logic        clk_i,     // system clock
    input  wire logic        go_i,      // start a pulse
    input  wire logic [19:0] len_i,     // low time in cycles
    output logic             trigger_o  // push-pull, idles high
);
    logic [19:0] left_q = 20'h00000;
    assign trigger_o = (left_q == 20'h00000);
    // countdown of the low time still to drive
    always @(posedge clk_i) begin
        if (go_i) begin
            left_q <= len_i;
        end else if (left_q != 20'h00000) begin
            left_q <= left_q - 20'h00001;
        end
    end
endmodule // wwd_mcu_model

// [wwd_pin_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; level moves once stages two and three agree
module wwd_pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_i,    // system clock
    input  wire logic reset_i,  // sync reset, active high
    input  wire logic pin_i,    // asynchronous pin
    output logic      level_o   // filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // stage one feeds only stage two
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // hold last level while stages disagree, a one-cycle glitch is dropped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            level_o <= RST_VAL;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end
endmodule // wwd_pin_sync

// [wwd_pkg.sv]
package wwd_pkg;
    // all durations in timer ticks unless noted
    localparam int unsigned POR_TICKS       = 10;
    localparam int unsigned SYNC_TICKS      = 450;
    localparam int unsigned SHORT_CLOSE     = 15;
    localparam int unsigned SHORT_OPEN      = 10;
    localparam int unsigned LONG_CLOSE      = 1500;
    localparam int unsigned LONG_OPEN       = 1000;
    localparam int unsigned PULSE_TICKS     = 4;
    localparam int unsigned TICK_W          = 12;
    // trigger pulse limits, in microseconds, and clock rate
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned TRIG_MIN_US     = 10;
    localparam int unsigned TRIG_MAX_US     = 5000;
    localparam int unsigned TRIG_MIN_CYC    = TRIG_MIN_US * CLK_MHZ;
    localparam int unsigned TRIG_MAX_CYC    = TRIG_MAX_US * CLK_MHZ;
    localparam int unsigned LOW_W           = 20;
    // pin synchroniser reset values (pull-ups idle high)
    localparam logic [2:0]  SYNC_RST        = 3'h7;

    typedef enum logic [2:0] {
        WWD_POR,
        WWD_SYNC,
        WWD_CLOSED,
        WWD_OPEN,
        WWD_PULSE
    } wwd_state_e;

    // conditioned pin levels and trigger events
    typedef struct packed {
        logic trigger_in;
        logic long_mode;
        logic supervise_on;
        logic valid_trigger_pulse;
        logic trigger_error;
    } wwd_pins_s;
endpackage

// [wwd_trigger_check.sv]
`timescale 1ns/1ps
// measures low pulses on the trigger line
module wwd_trigger_check #(
    parameter int unsigned MIN_CYC = wwd_pkg::TRIG_MIN_CYC,
    parameter int unsigned MAX_CYC = wwd_pkg::TRIG_MAX_CYC
) (
    input  wire logic clk_i,     // system clock
    input  wire logic reset_i,   // sync reset, active high
    input  wire logic trig_i,    // synchronised trigger level
    output logic      valid_o,   // one-cycle pulse on valid rising edge
    output logic      error_o    // level, low held too long
);
    localparam int W = wwd_pkg::LOW_W;
    logic [W-1:0] low_cnt_q;
    logic         trig_q;

    // count low time, saturating just past the maximum
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_cnt_q <= '0;
            trig_q    <= 1'b1;
        end else begin
            trig_q <= trig_i;
            if (trig_i) begin
                low_cnt_q <= '0;
            end else if (low_cnt_q <= W'(MAX_CYC)) begin
                low_cnt_q <= low_cnt_q + W'(1);
            end
        end
    end

    // judged at the returning rising edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            valid_o <= 1'b0;
        end else begin
            valid_o <= trig_i && !trig_q && low_cnt_q >= W'(MIN_CYC)
                       && low_cnt_q <= W'(MAX_CYC);
        end
    end

    // error stands until the line is high again
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            error_o <= 1'b0;
        end else begin
            error_o <= !trig_i && low_cnt_q > W'(MAX_CYC);
        end
    end
endmodule // wwd_trigger_check
